// file: rtl/fpte_pkg.sv
`default_nettype none
package fpte_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TEACH_MIN_MS   = 500;
  localparam int unsigned TEACH_CYCLES   = CLK_HZ / 1000 * TEACH_MIN_MS;
  // Gate time of the frequency meter: 100 ms, result in 10 Hz steps
  localparam int unsigned GATE_MS        = 100;
  localparam int unsigned GATE_CYCLES    = CLK_HZ / 1000 * GATE_MS;
  // Hysteresis 12 Hz, in counts per gate (12 Hz * 0.1 s)
  localparam int unsigned HYST_HZ        = 12;
  localparam int unsigned HYST_COUNTS    = HYST_HZ * GATE_MS / 1000;
  // Glitch filter length in clock cycles
  localparam int unsigned FILT_CYCLES    = 16;
  // Output scale: full-scale output frequency
  localparam int unsigned FULL_OUT_HZ    = 2000;
  localparam int unsigned FULL_HALF_CYC  = CLK_HZ / (2 * FULL_OUT_HZ);
  // Width of frequency counts
  localparam int unsigned FW             = 16;
  localparam logic [FW-1:0] REF_RESET    = 16'h0000;
  // ==========================================================
  // Modes
  typedef enum logic {
    FREQUENCY_SCALING_VARIANT,
    LIMIT_ALARM_VARIANT
  } fpte_mode_t;
endpackage : fpte_pkg
`default_nettype wire

// file: rtl/fpte_filter.sv
`default_nettype none
// ==========================================================
// Two-stage synchroniser followed by a stability filter
module fpte_filter #(
  parameter int unsigned N = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Raw and clean level
  input  wire logic din,
  output logic      dout
);
  logic             s1_q, s2_q, s1_d, s2_d;
  logic             out_q, out_d;
  logic [7:0]       cnt_q, cnt_d;

  // Output changes only after N steady samples
  always_comb begin
    s1_d  = din;
    s2_d  = s1_q;
    out_d = out_q;
    cnt_d = 8'h00;
    if (s2_q != out_q) begin
      cnt_d = cnt_q + 8'h01;
      if (cnt_q == 8'(N - 1)) begin
        out_d = s2_q;
        cnt_d = 8'h00;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign dout = out_q;
endmodule : fpte_filter
`default_nettype wire

// file: rtl/fpte_top.sv
`default_nettype none
module fpte_top #(
  parameter int unsigned TEACH_CYC = fpte_pkg::TEACH_CYCLES,
  parameter int unsigned GATE_CYC  = fpte_pkg::GATE_CYCLES,
  parameter int unsigned HALF_CYC  = fpte_pkg::FULL_HALF_CYC,
  parameter int unsigned FILT_N    = fpte_pkg::FILT_CYCLES
) (
  // Clock and reset
  input  wire logic SYS_CLK,
  input  wire logic ARST_N,
  // Configuration: 1 selects limit mode
  input  wire logic MODE_LIMIT,
  // Sensor and teach inputs
  input  wire logic SENSOR_PULSE,
  input  wire logic TEACH_IN,
  // Outputs
  output logic      FREQ_OUT,
  output logic      ALARM_OUT,
  output logic      LED_OUT,
  output logic      TEACH_DONE
);
  localparam int unsigned FW = fpte_pkg::FW;

  // ==========================================================
  // Input conditioning
  logic pulse_f, teach_f;
  fpte_filter #(.N(FILT_N)) u_pulse_filt (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .din    (SENSOR_PULSE),
    .dout   (pulse_f)
  );
  fpte_filter #(.N(FILT_N)) u_teach_filt (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .din    (TEACH_IN),
    .dout   (teach_f)
  );

  fpte_pkg::fpte_mode_t mode;
  assign mode = MODE_LIMIT ? fpte_pkg::LIMIT_ALARM_VARIANT
                           : fpte_pkg::FREQUENCY_SCALING_VARIANT;

  // ==========================================================
  // Frequency meter: rising edges per gate interval
  logic          prev_q, prev_d;
  logic [31:0]   gate_q, gate_d;
  logic [FW-1:0] edges_q, edges_d;
  logic [FW-1:0] freq_q, freq_d;
  logic          fvalid_q, fvalid_d;
  logic          rise;

  assign rise = pulse_f & ~prev_q;

  // Saturating edge count so fast input cannot wrap the result
  always_comb begin
    prev_d   = pulse_f;
    gate_d   = gate_q + 32'h0000_0001;
    edges_d  = edges_q;
    freq_d   = freq_q;
    fvalid_d = 1'b0;
    if (rise && edges_q != {FW{1'b1}}) begin
      edges_d = edges_q + 16'h0001;
    end
    if (gate_q == 32'(GATE_CYC - 1)) begin
      gate_d   = 32'h0000_0000;
      freq_d   = edges_d;
      edges_d  = 16'h0000;
      fvalid_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev_q   <= 1'b0;
      gate_q   <= 32'h0000_0000;
      edges_q  <= 16'h0000;
      freq_q   <= 16'h0000;
      fvalid_q <= 1'b0;
    end else begin
      prev_q   <= prev_d;
      gate_q   <= gate_d;
      edges_q  <= edges_d;
      freq_q   <= freq_d;
      fvalid_q <= fvalid_d;
    end
  end

  // ==========================================================
  // Teach timer and reference store
  typedef enum logic [1:0] {
    TS_IDLE,
    TS_TIMING,
    TS_WAIT_REL
  } fpte_teach_t;
  fpte_teach_t   ts_q, ts_d;
  logic [31:0]   tcnt_q, tcnt_d;
  logic [FW-1:0] ref_q, ref_d;
  logic          taught_q, taught_d;
  logic          done_q, done_d;

  // A held line teaches once; new teach needs release first
  always_comb begin
    ts_d     = ts_q;
    tcnt_d   = tcnt_q;
    ref_d    = ref_q;
    taught_d = taught_q;
    done_d   = 1'b0;
    case (ts_q)
      TS_IDLE: begin
        tcnt_d = 32'h0000_0000;
        if (teach_f) begin
          ts_d = TS_TIMING;
        end
      end
      TS_TIMING: begin
        if (!teach_f) begin
          ts_d = TS_IDLE;     // Too short, ignored
        end else if (tcnt_q == 32'(TEACH_CYC - 1)) begin
          ref_d    = freq_q;
          taught_d = 1'b1;
          done_d   = 1'b1;
          ts_d     = TS_WAIT_REL;
        end else begin
          tcnt_d = tcnt_q + 32'h0000_0001;
        end
      end
      TS_WAIT_REL: begin
        if (!teach_f) begin
          ts_d = TS_IDLE;
        end
      end
      default: ts_d = TS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ts_q     <= TS_IDLE;
      tcnt_q   <= 32'h0000_0000;
      ref_q    <= fpte_pkg::REF_RESET;
      taught_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      ts_q     <= ts_d;
      tcnt_q   <= tcnt_d;
      ref_q    <= ref_d;
      taught_q <= taught_d;
      done_q   <= done_d;
    end
  end

  // ==========================================================
  // Limit alarm with hysteresis
  logic          alarm_q, alarm_d;
  logic [FW:0]   clear_lvl;
  assign clear_lvl = {1'b0, ref_q} + (FW+1)'(fpte_pkg::HYST_COUNTS);

  // Alarm judged once per gate; teach forces alarm regardless
  always_comb begin
    alarm_d = alarm_q;
    if (done_q) begin
      alarm_d = 1'b1;
    end else if (fvalid_q && taught_q) begin
      if (freq_q < ref_q) begin
        alarm_d = 1'b1;
      end else if ({1'b0, freq_q} >= clear_lvl) begin
        alarm_d = 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // ==========================================================
  // Output pulse generator: DDA, phase += freq, wrap at ref
  // Full-scale toggles every HALF_CYC cycles; lower input scales it
  logic [31:0]   hcnt_q, hcnt_d;
  logic [FW:0]   acc_q, acc_d;
  logic          out_q, out_d;
  logic [FW:0]   acc_sum;

  assign acc_sum = acc_q + {1'b0, freq_q};

  always_comb begin
    hcnt_d = hcnt_q + 32'h0000_0001;
    acc_d  = acc_q;
    out_d  = out_q;
    if (done_q) begin
      acc_d  = {1'b0, ref_d};      // start phase at full
      hcnt_d = 32'h0000_0000;      // Restart tick, never run past the wrap
    end else if (hcnt_q == 32'(HALF_CYC - 1)) begin
      hcnt_d = 32'h0000_0000;
      if (taught_q && ref_q != 16'h0000) begin
        if (acc_sum >= {1'b0, ref_q}) begin
          acc_d = acc_sum - {1'b0, ref_q};
          out_d = ~out_q;
          // Input above reference: cap phase so it cannot overflow
          if (acc_d >= {1'b0, ref_q}) begin
            acc_d = {1'b0, ref_q};
          end
        end else begin
          acc_d = acc_sum;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hcnt_q <= 32'h0000_0000;
      acc_q  <= 17'h0_0000;
      out_q  <= 1'b0;
    end else begin
      hcnt_q <= hcnt_d;
      acc_q  <= acc_d;
      out_q  <= out_d;
    end
  end

  // ==========================================================
  // Outputs; output of the unused mode stays low
  always_comb begin
    if (mode == fpte_pkg::LIMIT_ALARM_VARIANT) begin
      FREQ_OUT  = 1'b0;
      ALARM_OUT = alarm_q;
      LED_OUT   = ~alarm_q;
    end else begin
      FREQ_OUT  = out_q;
      ALARM_OUT = 1'b0;
      LED_OUT   = out_q;
    end
  end
  assign TEACH_DONE = done_q;
endmodule : fpte_top
`default_nettype wire

// file: test/fpte_props.sv
`default_nettype none
// ======
// Port checker for the flow evaluator
module fpte_props #(
  parameter int unsigned TEACH_CYC = 200,
  parameter int unsigned FILT_N    = 4
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // Inputs
  input wire logic MODE_LIMIT,
  input wire logic SENSOR_PULSE,
  input wire logic TEACH_IN,
  // Outputs
  input wire logic FREQ_OUT,
  input wire logic ALARM_OUT,
  input wire logic LED_OUT,
  input wire logic TEACH_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  logic [15:0] hi_q;
  logic [15:0] hi_d;
  logic [7:0]  lo_q;
  logic [7:0]  lo_d;

  // Teach run length; dropouts the filter hides do not restart it
  always_comb begin
    hi_d = hi_q;
    lo_d = 8'h00;
    if (!TEACH_IN && lo_q == 8'(FILT_N - 1)) begin
      hi_d = 16'h0000;
      lo_d = lo_q;
    end else begin
      if (!TEACH_IN) lo_d = lo_q + 8'h01;
      if (hi_q != 16'hFFFF) hi_d = hi_q + 16'h0001;
    end
  end

  // Run length registers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hi_q <= 16'h0000;
      lo_q <= 8'h00;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  // Toggle followed by 8 quiet cycles
  sequence s_toggle;
    $changed(FREQ_OUT);
  endsequence
  sequence s_quiet;
    (!$changed(FREQ_OUT)) [*8];
  endsequence

  // Filter latency stays under 12 cycles
  AST_TEACH_LEN: assert property (TEACH_DONE |->
    $past(hi_q, 12) >= 16'(TEACH_CYC - 12)) else $error("teach too short");
  AST_TEACH_ONE: assert property (TEACH_DONE |=> !TEACH_DONE)
    else $error("teach done not single");
  AST_ALARM_TEACH: assert property (MODE_LIMIT && TEACH_DONE |=>
    ALARM_OUT) else $error("no alarm after teach");
  AST_LED_LIM: assert property (MODE_LIMIT |-> LED_OUT == !ALARM_OUT)
    else $error("led wrong in limit mode");
  AST_LED_SCL: assert property (!MODE_LIMIT |-> LED_OUT == FREQ_OUT)
    else $error("led wrong in scaling mode");
  AST_IDLE: assert property (MODE_LIMIT ? !FREQ_OUT : !ALARM_OUT)
    else $error("inactive output moved");
  AST_FULL: assert property (!MODE_LIMIT && TEACH_DONE |->
    ##[1:12] $changed(FREQ_OUT)) else $error("no output after teach");
  AST_RATE: assert property (s_toggle |=> s_quiet)
    else $error("output above full scale");
  AST_ALARM_GATE: assert property ($changed(ALARM_OUT) |=>
    ($stable(ALARM_OUT) || $past(TEACH_DONE)) [*8])
    else $error("alarm moved inside gate");
endmodule : fpte_props
`default_nettype wire

// file: test/fpte_sensor.sv
`default_nettype none
// ======
// Rotor pulse source, square wave
module fpte_sensor (
  // Clock
  input  wire logic        clk,
  // Half period in cycles, 0 stops it
  input  wire logic [15:0] half,
  // Pulse train
  output var  logic        pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt = 16'h0000;
  initial pulse = 1'b0;
  // Stopped rotor rests low, no stale edges
  always @(posedge clk) begin
    #1;
    if (half == 16'h0000) begin
      pulse = 1'b0;
    end else if (cnt + 16'h0001 >= half) begin
      pulse = !pulse;
      cnt = 16'h0000;
    end else begin
      cnt = cnt + 16'h0001;
    end
  end
endmodule : fpte_sensor
`default_nettype wire

// file: test/fpte_top_bench.sv
`default_nettype none
module fpte_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Stimulus and observed wires
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        mode  = 1'b1;
  logic        teach = 1'b0;
  logic [15:0] half  = 16'h000A;
  logic        pulse;
  logic        fout;
  logic        alarm;
  logic        led;
  logic        done;
  int          fails     = 0;
  int          cmp_count = 0;

  // 100 MHz clock
  always #5 clk = !clk;

  fpte_sensor i_sensor (.clk(clk), .half(half), .pulse(pulse));

  // Short counts keep the run brief
  fpte_top #(.TEACH_CYC(200), .GATE_CYC(100), .HALF_CYC(10), .FILT_N(4))
    i_dut (
    .SYS_CLK(clk), .ARST_N(rst_n), .MODE_LIMIT(mode),
    .SENSOR_PULSE(pulse), .TEACH_IN(teach), .FREQ_OUT(fout),
    .ALARM_OUT(alarm), .LED_OUT(led), .TEACH_DONE(done));

  // ======
  // Shared helpers
  task automatic check(input logic seen, input logic exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check

  // Inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Mode only changes under reset
  task automatic restart(input logic m);
    rst_n = 1'b0;
    mode  = m;
    step(10);
    rst_n = 1'b1;
  endtask : restart

  // Hold teach n cycles, 2-cycle dropout at gap if set, watch 20 more
  task automatic teach_for(input int n, input int gap, output logic got);
    got   = 1'b0;
    teach = 1'b1;
    for (int i = 0; i < n + 20; i++) begin
      if (i == n) teach = 1'b0;
      if (gap > 0 && i == gap) teach = 1'b0;
      if (gap > 0 && i == gap + 2) teach = 1'b1;
      step(1);
      if (done === 1'b1) got = 1'b1;
    end
  endtask : teach_for

  task automatic toggles(input int n, output int t);
    logic prev;
    t = 0;
    repeat (n) begin
      prev = fout;
      step(1);
      if (fout !== prev) t++;
    end
  endtask : toggles

  // ======
  // Scenarios: ref 5 edges per gate at half period 10
  task automatic test_limit;
    logic got;
    restart(1'b1);
    half = 16'h000A;
    step(300);
    teach_for(100, 0, got);
    check(got, 1'b0, "short teach taken");
    teach_for(230, 0, got);
    check(got, 1'b1, "teach not taken");
    check(alarm, 1'b1, "no alarm after teach");
    check(led, 1'b0, "led lit in alarm");
    step(300);
    check(alarm, 1'b1, "cleared below hysteresis");
    half = 16'h0008;
    step(300);
    check(alarm, 1'b0, "alarm not cleared");
    check(led, 1'b1, "led dark without alarm");
    half = 16'h0019;
    step(300);
    check(alarm, 1'b1, "no alarm on low flow");
    $display("limit test done");
  endtask : test_limit

  // Dropout shorter than the filter must not restart teach timing
  task automatic test_glitch;
    logic got;
    restart(1'b1);
    half = 16'h000A;
    step(300);
    check(alarm, 1'b0, "alarm before any teach");
    teach_for(230, 100, got);
    check(got, 1'b1, "dropout restarted teach");
    check(alarm, 1'b1, "no alarm after teach");
    $display("glitch test done");
  endtask : test_glitch

  task automatic test_scale;
    logic got;
    int   t;
    restart(1'b0);
    half = 16'h000A;
    step(300);
    toggles(500, t);
    check(t == 0, 1'b1, "output before teach");
    teach_for(230, 0, got);
    check(got, 1'b1, "teach not taken");
    toggles(1000, t);
    check(t inside {[99:101]}, 1'b1, "not full scale");
    half = 16'h0019;
    step(200);
    toggles(1000, t);
    check(t inside {[38:42]}, 1'b1, "not proportional");
    check(alarm, 1'b0, "alarm in scaling mode");
    $display("scaling test done");
  endtask : test_scale

  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Tests take about 5400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    test_limit();
    test_glitch();
    test_scale();
    results();
  end
endmodule : fpte_top_bench

bind fpte_top fpte_props #(.TEACH_CYC(TEACH_CYC), .FILT_N(FILT_N)) i_props (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .MODE_LIMIT(MODE_LIMIT),
  .SENSOR_PULSE(SENSOR_PULSE), .TEACH_IN(TEACH_IN),
  .FREQ_OUT(FREQ_OUT), .ALARM_OUT(ALARM_OUT), .LED_OUT(LED_OUT),
  .TEACH_DONE(TEACH_DONE));
`default_nettype wire
